/* include/clp_regs.svh */
// Purpose: Offsets, field positions and reset values of the LCD port
// Assumes: 10-bit ISA I/O decode
// Notes: Definitions only
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH

`define CLP_ADDR_W 10
`define CLP_DATA_W 8
`define CLP_OFS_DATA_LATCH 10'h201
`define CLP_OFS_CTRL_LATCH 10'h2B0
`define CLP_OFS_BUS_DATA 10'h2B8
`define CLP_RST_LATCH 8'h00
`define CLP_CTRL_WR_BIT 0
`define CLP_CTRL_CD_BIT 1
`define CLP_CTRL_RD_BIT 2
`define CLP_CTRL_NIB_BIT 3
`define CLP_CTRL_LSEL_BIT 4
`define CLP_ADDR_A0_BIT 0
`define CLP_ADDR_A1_BIT 1
`define CLP_LOW_NIBBLE_MASK 8'hF0
`define CLP_JMP_ALL_12 4'h0
`define CLP_JMP_ALL_23 4'hF
// Mixed pattern, so no mode is chosen before real jumpers are sampled
`define CLP_JMP_SYNC_RST 4'h5
`define CLP_FIFO_DEPTH 4
`define CLP_PACE_DIV 4

`endif

/* include/clp_pkg.sv */
// Purpose: Types shared by the LCD port files
// Assumes: Constants come from clp_regs.svh
// Notes: Structs carry sampled bus and LCD pin groups
`include "clp_regs.svh"
package clp_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_LATCHED,
    MODE_BUS
  } clp_mode_e;

  typedef struct packed {
    logic [`CLP_ADDR_W-1:0] addr;
    logic [`CLP_DATA_W-1:0] data;
    logic iow_n;
    logic ior_n;
    logic aen;
  } clp_isa_s;

  typedef struct packed {
    logic [`CLP_DATA_W-1:0] data_out;
    logic data_oe;
    logic write_strobe;
    logic cmd_data_select;
    logic read_strobe;
    logic read_write;
    logic line1_enable;
    logic line2_enable;
    logic addr1;
    logic chip_select_n;
    logic reset_drive;
  } clp_lcd_s;
endpackage : clp_pkg

/* design/clp_fifo.sv */
// Purpose: Small FIFO between host writes and the data latch
// Assumes: Single clock, synchronous valid/ready on both sides
// Notes: Full and empty come straight from the fill count
`timescale 1ns/1ns
`default_nettype none
module clp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("clp_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end
endmodule : clp_fifo
`default_nettype wire

/* design/clp_port.sv */
// Purpose: Character/dot-matrix LCD port on ISA I/O space, two modes
// Assumes: All ISA pins, jumpers and LCD data inputs are asynchronous
// Notes: Latched-mode writes are taken on the falling edge of the write strobe
//
// Behaviour
// [R1] Four jumpers choose latched or bus mode
// [R2] Latched: write 201h drives LCD data lines
// [R3] Data latch bits map one-to-one onto lines
// [R4] Write 2B0h sets write, select, read outputs
// [R5] No reads in latched mode
// [R6] Four-bit format uses upper data lines only
// [R7] Two lines get separate enables, shared rest
// [R8] Read/write high reads, low writes
// [R9] Register select high command, low data
// [R10] LCD takes data on enable fall
// [R11] Bus mode: 2B8h reads and writes LCD
// [R12] Bus strobes and A0 pass to LCD
// [R13] Bus address bit 1 goes out too
// [R14] Chip select asserted on 2B8h decode
// [R15] LCD selected only by low chip select
// [R16] LCD reset follows system reset drive
// [R17] Latches hold until written again
// [R18] Latches clear to zero on reset
`include "clp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module clp_port #(
  parameter int FIFO_DEPTH = `CLP_FIFO_DEPTH,
  parameter int PACE_DIV = `CLP_PACE_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ISA bus pins
  input wire logic [`CLP_ADDR_W-1:0] isa_addr,
  input wire logic isa_iow_n,
  input wire logic isa_ior_n,
  input wire logic isa_aen,
  input wire logic [`CLP_DATA_W-1:0] isa_data_in,
  output logic [`CLP_DATA_W-1:0] isa_data_out,
  output logic isa_data_oe,
  output logic isa_iochrdy,
  input wire logic system_reset_drive,
  // Mode jumpers, bit set means position 2-3
  input wire logic [3:0] mode_jumpers,
  // LCD connector
  input wire logic [`CLP_DATA_W-1:0] lcd_data_in,
  output var clp_pkg::clp_lcd_s lcd
);
  initial begin
    if (PACE_DIV < 1 || FIFO_DEPTH < 2) begin
      $error("clp_port: PACE_DIV must be >= 1 and FIFO_DEPTH >= 2");
    end
  end

  // Two-stage synchronisers; stage one is read only by stage two
  clp_pkg::clp_isa_s isa_s1_q;
  clp_pkg::clp_isa_s isa_s2_q;
  clp_pkg::clp_isa_s isa_in;
  logic [3:0] jmp_s1_q;
  logic [3:0] jmp_s2_q;
  logic [`CLP_DATA_W-1:0] lcd_s1_q;
  logic [`CLP_DATA_W-1:0] lcd_s2_q;
  logic rst_s1_q;
  logic rst_s2_q;

  assign isa_in = '{addr: isa_addr, data: isa_data_in, iow_n: isa_iow_n,
                    ior_n: isa_ior_n, aen: isa_aen};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isa_s1_q <= '{addr: '0, data: '0, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
      isa_s2_q <= '{addr: '0, data: '0, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
      // All-zero would decode as latched and drive LCD data in bus mode
      jmp_s1_q <= `CLP_JMP_SYNC_RST;
      jmp_s2_q <= `CLP_JMP_SYNC_RST;
      lcd_s1_q <= '0;
      lcd_s2_q <= '0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      isa_s1_q <= isa_in;
      isa_s2_q <= isa_s1_q;
      jmp_s1_q <= mode_jumpers;
      jmp_s2_q <= jmp_s1_q;
      lcd_s1_q <= lcd_data_in;
      lcd_s2_q <= lcd_s1_q;
      rst_s1_q <= system_reset_drive;
      rst_s2_q <= rst_s1_q;
    end
  end

  function automatic logic hit(input clp_pkg::clp_isa_s b,
                               input logic [`CLP_ADDR_W-1:0] ofs);
    hit = !b.aen && (b.addr == ofs);
  endfunction : hit

  // Mixed jumpers leave the port idle rather than half-wired
  clp_pkg::clp_mode_e mode_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= clp_pkg::MODE_OFF;
    end else begin
      case (jmp_s2_q)
        `CLP_JMP_ALL_12: mode_q <= clp_pkg::MODE_LATCHED; // R1
        `CLP_JMP_ALL_23: mode_q <= clp_pkg::MODE_BUS; // R1
        default: mode_q <= clp_pkg::MODE_OFF;
      endcase
    end
  end

  logic latched;
  logic bus_mode;
  assign latched = (mode_q == clp_pkg::MODE_LATCHED);
  assign bus_mode = (mode_q == clp_pkg::MODE_BUS);

  // Write strobe edge, from the synchronised copy only
  logic iow_prev_q;
  logic wr_fall;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      iow_prev_q <= 1'b1;
    end else begin
      iow_prev_q <= isa_s2_q.iow_n;
    end
  end
  assign wr_fall = iow_prev_q && !isa_s2_q.iow_n;

  logic sel_data;
  logic sel_ctrl;
  logic sel_bus;
  assign sel_data = hit(isa_s2_q, `CLP_OFS_DATA_LATCH);
  assign sel_ctrl = hit(isa_s2_q, `CLP_OFS_CTRL_LATCH);
  assign sel_bus = hit(isa_s2_q, `CLP_OFS_BUS_DATA);

  // Data writes wait here while the FIFO is full; IOCHRDY stalls the host
  logic pend_q;
  logic [`CLP_DATA_W-1:0] pend_data_q;
  logic fifo_in_ready;
  logic fifo_push;
  assign fifo_push = pend_q && fifo_in_ready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      pend_data_q <= `CLP_RST_LATCH;
    end else if (wr_fall && sel_data && latched) begin
      pend_q <= 1'b1; // R2
      pend_data_q <= isa_s2_q.data;
    end else if (fifo_push) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isa_iochrdy <= 1'b1;
    end else begin
      isa_iochrdy <= !(pend_q && !fifo_in_ready);
    end
  end

  // Pacing divider gives the LCD time between successive data bytes
  localparam int PW = (PACE_DIV > 1) ? $clog2(PACE_DIV) : 1;
  logic [PW-1:0] pace_q;
  logic pace_en;
  assign pace_en = (pace_q == PW'(PACE_DIV - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pace_q <= '0;
    end else begin
      pace_q <= pace_en ? '0 : pace_q + PW'(1);
    end
  end

  logic fifo_valid;
  logic fifo_pop;
  logic [`CLP_DATA_W-1:0] fifo_data;
  assign fifo_pop = fifo_valid && pace_en;

  clp_fifo #(
    .WIDTH(`CLP_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(pend_q),
    .in_ready(fifo_in_ready),
    .in_data(pend_data_q),
    .out_valid(fifo_valid),
    .out_ready(pace_en),
    .out_data(fifo_data)
  );

  // Latches hold until rewritten; reset clears both
  logic [`CLP_DATA_W-1:0] data_latch_q;
  logic [`CLP_DATA_W-1:0] ctrl_latch_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_latch_q <= `CLP_RST_LATCH; // R18
    end else if (fifo_pop) begin
      data_latch_q <= fifo_data; // R2 R17
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_latch_q <= `CLP_RST_LATCH; // R18
    end else if (wr_fall && sel_ctrl && latched) begin
      ctrl_latch_q <= isa_s2_q.data; // R4 R17
    end
  end

  logic nibble_mode;
  logic line_sel;
  logic bus_rd;
  logic bus_wr;
  assign nibble_mode = ctrl_latch_q[`CLP_CTRL_NIB_BIT];
  assign line_sel = ctrl_latch_q[`CLP_CTRL_LSEL_BIT];
  assign bus_rd = bus_mode && sel_bus && !isa_s2_q.ior_n;
  assign bus_wr = bus_mode && sel_bus && !isa_s2_q.iow_n;

  // Registered LCD pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lcd <= '{data_out: '0, data_oe: 1'b0, write_strobe: 1'b0,
               cmd_data_select: 1'b0, read_strobe: 1'b0, read_write: 1'b0,
               line1_enable: 1'b0, line2_enable: 1'b0, addr1: 1'b0,
               chip_select_n: 1'b1, reset_drive: 1'b0};
    end else begin
      lcd.reset_drive <= rst_s2_q; // R16
      case (mode_q)
        clp_pkg::MODE_LATCHED: begin
          lcd.data_out <= nibble_mode ? (data_latch_q & `CLP_LOW_NIBBLE_MASK)
                                      : data_latch_q; // R3 R6
          lcd.data_oe <= 1'b1; // R5
          lcd.write_strobe <= ctrl_latch_q[`CLP_CTRL_WR_BIT]; // R4 R10
          lcd.cmd_data_select <= ctrl_latch_q[`CLP_CTRL_CD_BIT]; // R4 R9
          lcd.read_strobe <= ctrl_latch_q[`CLP_CTRL_RD_BIT]; // R4
          lcd.read_write <= ctrl_latch_q[`CLP_CTRL_RD_BIT]; // R8
          lcd.line1_enable <= ctrl_latch_q[`CLP_CTRL_WR_BIT] && !line_sel; // R7
          lcd.line2_enable <= ctrl_latch_q[`CLP_CTRL_WR_BIT] && line_sel; // R7
          lcd.addr1 <= 1'b0;
          lcd.chip_select_n <= 1'b1;
        end
        clp_pkg::MODE_BUS: begin
          lcd.data_out <= isa_s2_q.data; // R11
          lcd.data_oe <= bus_wr; // R12
          lcd.write_strobe <= isa_s2_q.iow_n; // R12
          lcd.cmd_data_select <= isa_s2_q.addr[`CLP_ADDR_A0_BIT]; // R12 R9
          lcd.read_strobe <= isa_s2_q.ior_n; // R12
          lcd.read_write <= !isa_s2_q.ior_n; // R8
          lcd.line1_enable <= 1'b0;
          lcd.line2_enable <= 1'b0;
          lcd.addr1 <= isa_s2_q.addr[`CLP_ADDR_A1_BIT]; // R13
          lcd.chip_select_n <= !sel_bus; // R14 R15
        end
        default: begin
          lcd.data_out <= '0;
          lcd.data_oe <= 1'b0;
          lcd.write_strobe <= 1'b0;
          lcd.cmd_data_select <= 1'b0;
          lcd.read_strobe <= 1'b0;
          lcd.read_write <= 1'b0;
          lcd.line1_enable <= 1'b0;
          lcd.line2_enable <= 1'b0;
          lcd.addr1 <= 1'b0;
          lcd.chip_select_n <= 1'b1;
        end
      endcase
    end
  end

  // Bus-mode read returns the LCD byte while the read strobe is held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isa_data_out <= '0;
      isa_data_oe <= 1'b0;
    end else begin
      isa_data_out <= lcd_s2_q; // R11
      isa_data_oe <= bus_rd; // R11 R5
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_DATA_CAPTURE: assert property ( // R2
    wr_fall && sel_data && latched |=> pend_q && pend_data_q == $past(isa_s2_q.data))
    else $error("data write not captured");

  AST_DATA_LATCH: assert property ( // R3
    fifo_pop |=> data_latch_q == $past(fifo_data))
    else $error("data latch missed FIFO word");

  AST_CTRL_LATCH: assert property ( // R4
    wr_fall && sel_ctrl && latched |=> ctrl_latch_q == $past(isa_s2_q.data))
    else $error("control latch not written");

  AST_CTRL_PIN: assert property ( // R4
    latched && $past(latched) |-> ##1
      lcd.write_strobe == $past(ctrl_latch_q[`CLP_CTRL_WR_BIT])
      && lcd.cmd_data_select == $past(ctrl_latch_q[`CLP_CTRL_CD_BIT]))
    else $error("control pins do not follow latch");

  AST_NIBBLE: assert property ( // R6
    latched && nibble_mode |=> lcd.data_out[3:0] == 4'h0)
    else $error("low nibble driven in four-bit format");

  AST_LINE_EN: assert property ( // R7
    !(lcd.line1_enable && lcd.line2_enable))
    else $error("both line enables high");

  AST_BUS_RW: assert property ( // R8
    bus_mode ##1 bus_mode |-> lcd.read_write == !$past(isa_s2_q.ior_n))
    else $error("read/write level wrong in bus mode");

  AST_CS: assert property ( // R14
    bus_mode && sel_bus |=> !lcd.chip_select_n)
    else $error("chip select not asserted on decode");

  AST_HOLD: assert property ( // R17
    !(wr_fall && sel_ctrl) |=> $stable(ctrl_latch_q))
    else $error("control latch changed without a write");

  AST_BUS_RD: assert property ( // R11
    isa_data_oe |-> $past(bus_mode) && $past(!isa_s2_q.ior_n))
    else $error("bus driven outside a bus-mode read");

  AST_STALL: assert property ( // R2
    pend_q && !fifo_in_ready |=> !isa_iochrdy)
    else $error("host not stalled on full FIFO");
endmodule : clp_port
`default_nettype wire

/* bench/clp_lcd_model.sv */
// Purpose: Behavioural LCD controller module on the far side of the port
// Assumes: Outputs of the port are registered, sampled on clk
// Notes: Released data lines show a changing pattern, never the last value
`timescale 1ns/1ns
`default_nettype none
module clp_lcd_model #(
  parameter logic [7:0] RD_VAL = 8'h3C
) (
  // Clock
  input wire logic clk,
  // Pins from the port
  input wire clp_pkg::clp_lcd_s lcd,
  // Pins back to the port, and the byte taken on the enable fall for the bench
  output logic [7:0] lcd_data_in,
  output logic [7:0] taken_q
);
  logic [7:0] last_q;
  logic en_q;
  wire logic en = lcd.line1_enable | lcd.line2_enable;
  always_comb begin
    if (lcd.data_oe) begin
      lcd_data_in = lcd.data_out;
    end else if (!lcd.chip_select_n && lcd.read_write) begin
      lcd_data_in = RD_VAL;
    end else begin
      lcd_data_in = ~last_q;
    end
  end
  always_ff @(posedge clk) begin
    last_q <= lcd_data_in;
    en_q <= en;
  end
  // Data taken on the enable fall; the select level is not looked at
  always_ff @(posedge clk) begin
    if (en_q && !en) begin
      taken_q <= lcd.data_out;
    end
  end
endmodule : clp_lcd_model
`default_nettype wire

/* bench/tb_character_lcd_port.sv */
// Purpose: Self-checking bench for the LCD port in both modes
// Assumes: Inputs change on the falling clock edge
// Notes: Waits cover the two sync flops and the pacing of the FIFO
`include "clp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_character_lcd_port;
  logic clk;
  logic arst_n;
  logic [9:0] isa_addr;
  logic isa_iow_n;
  logic isa_ior_n;
  logic isa_aen;
  logic [7:0] isa_data_in;
  logic [7:0] isa_data_out;
  logic isa_data_oe;
  logic isa_iochrdy;
  logic system_reset_drive;
  logic [3:0] mode_jumpers;
  logic [7:0] lcd_data_in;
  logic [7:0] taken;
  logic [7:0] last_out = 8'h00;
  logic [7:0] seen_q[$];
  clp_pkg::clp_lcd_s lcd;
  int err_count;
  int comparisons;
  int cycles;

  clp_port #(.FIFO_DEPTH(4), .PACE_DIV(4)) i_clp_port (
    .clk(clk), .arst_n(arst_n), .isa_addr(isa_addr), .isa_iow_n(isa_iow_n),
    .isa_ior_n(isa_ior_n), .isa_aen(isa_aen), .isa_data_in(isa_data_in),
    .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe), .isa_iochrdy(isa_iochrdy),
    .system_reset_drive(system_reset_drive), .mode_jumpers(mode_jumpers),
    .lcd_data_in(lcd_data_in), .lcd(lcd));
  clp_lcd_model #(.RD_VAL(8'h3C)) i_clp_lcd_model (
    .clk(clk), .lcd(lcd), .lcd_data_in(lcd_data_in), .taken_q(taken));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results;
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end

  // Records every change of the LCD data lines, in order
  always @(negedge clk) begin
    if (lcd.data_out !== last_out) begin
      seen_q.push_back(lcd.data_out);
      last_out = lcd.data_out;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic put(input logic [9:0] a, input logic [7:0] d, input logic w, input logic r,
                     input int n);
    @(negedge clk);
    isa_addr = a;
    isa_data_in = d;
    isa_iow_n = w;
    isa_ior_n = r;
    repeat (n) @(negedge clk);
  endtask : put

  // Strobe held low while the port stalls the host
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    put(a, d, 1'b0, 1'b1, 4);
    while (isa_iochrdy !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(isa_iochrdy, 8'h01);
    put(a, d, 1'b1, 1'b1, 4);
  endtask : io_wr

  task automatic data_wr(input logic [7:0] d);
    io_wr(`CLP_OFS_DATA_LATCH, d);
    repeat (10) @(negedge clk);
  endtask : data_wr

  initial begin
    arst_n = 1'b0;
    isa_addr = '0;
    isa_iow_n = 1'b1;
    isa_ior_n = 1'b1;
    isa_aen = 1'b0;
    isa_data_in = '0;
    system_reset_drive = 1'b0;
    mode_jumpers = `CLP_JMP_ALL_12;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(lcd.data_out, 8'h00);
    chk({lcd.write_strobe, lcd.cmd_data_select, lcd.read_strobe}, 8'h00);
    chk({lcd.chip_select_n, isa_data_oe, isa_iochrdy}, 8'h05);
    for (int i = 0; i < 8; i++) begin
      io_wr(`CLP_OFS_CTRL_LATCH, 8'(i));
      chk({lcd.read_strobe, lcd.cmd_data_select, lcd.write_strobe}, 8'(i));
      chk(lcd.read_write, 8'(i >> 2));
    end
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h01);
    chk({lcd.line2_enable, lcd.line1_enable}, 8'h01);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h11);
    chk({lcd.line2_enable, lcd.line1_enable}, 8'h02);
    for (int i = 0; i < 8; i++) begin
      data_wr(8'h01 << i);
      chk(lcd.data_out, 8'h01 << i);
    end
    chk(lcd.line2_enable, 8'h01);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h00);
    data_wr(8'h5A);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h01);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h00);
    chk(taken, 8'h5A);
    chk(lcd.data_out, 8'h5A);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h08);
    data_wr(8'hFF);
    chk(lcd.data_out, 8'hF0);
    put(`CLP_OFS_DATA_LATCH, 8'h00, 1'b1, 1'b0, 5);
    chk(isa_data_oe, 8'h00);
    put(`CLP_OFS_DATA_LATCH, 8'h00, 1'b1, 1'b1, 3);
    io_wr(`CLP_OFS_CTRL_LATCH, 8'h00);
    repeat (12) @(negedge clk);
    seen_q.delete();
    for (int i = 1; i < 5; i++) io_wr(`CLP_OFS_DATA_LATCH, 8'(i * 17));
    repeat (20) @(negedge clk);
    chk(8'(seen_q.size()), 8'h04);
    for (int i = 0; i < seen_q.size(); i++) chk(seen_q[i], 8'((i + 1) * 17));
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(lcd.data_out, 8'h00);
    arst_n = 1'b1;
    mode_jumpers = `CLP_JMP_ALL_23;
    repeat (6) @(negedge clk);
    put(`CLP_OFS_BUS_DATA, 8'hC3, 1'b0, 1'b1, 5);
    chk({lcd.chip_select_n, lcd.data_oe, lcd.write_strobe}, 8'h02);
    chk({lcd.read_write, lcd.cmd_data_select, lcd.addr1}, 8'h00);
    chk(lcd.data_out, 8'hC3);
    put(10'h2BB, 8'h00, 1'b0, 1'b1, 5);
    chk({lcd.chip_select_n, lcd.cmd_data_select, lcd.addr1}, 8'h07);
    // LCD byte needs pin sync, LCD answer, two sync flops and the output flop
    put(`CLP_OFS_BUS_DATA, 8'h00, 1'b1, 1'b0, 7);
    chk({isa_data_oe, lcd.read_write, lcd.read_strobe, lcd.chip_select_n}, 8'h0C);
    chk(isa_data_out, 8'h3C);
    isa_aen = 1'b1;
    repeat (5) @(negedge clk);
    chk(lcd.chip_select_n, 8'h01);
    isa_aen = 1'b0;
    put(`CLP_OFS_BUS_DATA, 8'h00, 1'b1, 1'b1, 3);
    system_reset_drive = 1'b1;
    repeat (5) @(negedge clk);
    chk(lcd.reset_drive, 8'h01);
    system_reset_drive = 1'b0;
    mode_jumpers = 4'h5;
    repeat (6) @(negedge clk);
    put(`CLP_OFS_BUS_DATA, 8'h00, 1'b1, 1'b0, 5);
    chk({lcd.chip_select_n, isa_data_oe}, 8'h02);
    put(`CLP_OFS_BUS_DATA, 8'h00, 1'b1, 1'b1, 3);
    results();
  end
endmodule : tb_character_lcd_port
`default_nettype wire
